//--- hw/rx_timeout_counter.v
// Receive time-out counter running on baud ticks, restarted by FIFO activity
`timescale 1ns/100ps

module rx_timeout_counter (
    input wire mclk,
    input wire reset,
    input wire ce,
    input wire baud_tick,
    input wire rx_activity,
    input wire rx_not_empty,
    input wire [7:0] compare_value,
    output reg hit
);

    reg [7:0] timeout_counter;

    // ****************************************************************
    // Counter
    // ****************************************************************
    // Holds at the compare value so a single stale period gives one hit only
    always @(posedge mclk) begin
        if (reset) begin
            timeout_counter <= 8'h00;
            hit <= 1'b0;
        end else if (ce) begin
            hit <= 1'b0;
            if (rx_activity || !rx_not_empty) begin
                timeout_counter <= 8'h00;
            end else if (timeout_counter == compare_value) begin
                timeout_counter <= timeout_counter;
            end else if (baud_tick) begin
                timeout_counter <= timeout_counter + 8'h01;
                // Hit pulses on the tick that makes the count equal
                hit <= ((timeout_counter + 8'h01) == compare_value);
            end
        end
    end

endmodule // rx_timeout_counter

//--- hw/uart_interrupt_status.v
// UART interrupt status logic with its event flags, enables and register port
`timescale 1ns/100ps
`include "uart_isr_consts.vh"

module uart_interrupt_status (
    input wire mclk,
    input wire reset,
    input wire ce,
    input wire [7:0] addr,
    input wire [31:0] wdata,
    input wire wr_en,
    input wire rd_en,
    output reg [31:0] rdata,
    input wire rx_push,
    input wire rx_char_bit9,
    input wire [4:0] rx_fifo_count,
    input wire tx_overflow_event,
    input wire tx_last_to_shift,
    input wire break_event,
    input wire framing_event,
    input wire parity_event,
    input wire cts_level,
    input wire baud_tick,
    output reg rx_buf_read,
    output reg tx_hold_write,
    output reg [31:0] int_status
);

    // ****************************************************************
    // Helper functions
    // ****************************************************************
    // Sticky flag update: a set in the same cycle as a clear wins
    function next_sticky;
        input cur;
        input set;
        input clr;
        begin
            next_sticky = set | (cur & ~clr);
        end
    endfunction

    // Write-one-to-clear strobe for one bit of a given register
    function w1c_hit;
        input [7:0] a;
        input [7:0] ofs;
        input we;
        input bitval;
        begin
            w1c_hit = we & (a == ofs) & bitval;
        end
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    reg [5:0] enable_bits;
    reg [4:0] rx_trigger_level;
    reg rs485_addr_en;
    reg [7:0] timeout_compare_value;
    reg rx_over_flag;
    reg tx_over_flag;
    reg break_flag;
    reg framing_error_flag;
    reg parity_error_flag;
    reg rs485_addr_detect_flag;
    reg cts_delta_flag;
    reg cts_prev;
    reg timeout_flag;
    reg tx_empty_flag;
    reg rx_avail_flag;

    wire timeout_hit;
    wire rd_data;
    wire wr_data;
    wire clr_rx_over;
    wire clr_tx_over;
    wire clr_break;
    wire clr_framing;
    wire clr_parity;
    wire clr_addr_det;
    wire clr_cts_delta;
    wire rx_overflow_now;
    wire addr_char_now;
    wire cts_changed;
    wire buffer_error_flag;
    wire line_status_flag;
    wire cts_change_flag;
    wire [5:0] flags;
    wire [5:0] indicators;
    wire [31:0] status_word;
    wire [31:0] fifo_status_word;
    reg [31:0] next_rdata;

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    // The data port is shared: a read pops the receiver, a write loads the transmitter
    assign rd_data = rd_en & (addr == `OFS_DATA);
    assign wr_data = wr_en & (addr == `OFS_DATA);

    // Write-one-to-clear strobes, decoded once here so every FIFO status flag sees the same offset check
    assign clr_rx_over = w1c_hit(addr, `OFS_FIFO_STATUS, wr_en, wdata[`FS_RX_OVER]);
    assign clr_tx_over = w1c_hit(addr, `OFS_FIFO_STATUS, wr_en, wdata[`FS_TX_OVER]);
    assign clr_break = w1c_hit(addr, `OFS_FIFO_STATUS, wr_en, wdata[`FS_BREAK]);
    assign clr_framing = w1c_hit(addr, `OFS_FIFO_STATUS, wr_en, wdata[`FS_FRAMING]);
    assign clr_parity = w1c_hit(addr, `OFS_FIFO_STATUS, wr_en, wdata[`FS_PARITY]);
    assign clr_addr_det = w1c_hit(addr, `OFS_FIFO_STATUS, wr_en, wdata[`FS_ADDR_DET]);
    assign clr_cts_delta = w1c_hit(addr, `OFS_MODEM, wr_en, wdata[`MODEM_CTS_DELTA]);

    // ****************************************************************
    // Event detection
    // ****************************************************************
    // A push while the FIFO already holds sixteen entries is an overflow
    assign rx_overflow_now = rx_push & (rx_fifo_count == `RX_FIFO_DEPTH);
    assign addr_char_now = rs485_addr_en & rx_push & rx_char_bit9;
    assign cts_changed = cts_level ^ cts_prev;

    // ****************************************************************
    // Time-out counter
    // ****************************************************************
    // Any receive FIFO activity, push or software read, restarts the count
    rx_timeout_counter timeout_unit (
        .mclk(mclk),
        .reset(reset),
        .ce(ce),
        .baud_tick(baud_tick),
        .rx_activity(rx_push | rd_data),
        .rx_not_empty(rx_fifo_count != 5'h00),
        .compare_value(timeout_compare_value),
        .hit(timeout_hit)
    );

    // ****************************************************************
    // Control registers
    // ****************************************************************
    // Enable, FIFO control and time-out compare are plain read/write fields
    always @(posedge mclk) begin
        if (reset) begin
            enable_bits <= `RESET_ENABLE;
            rx_trigger_level <= `RESET_TRIGGER;
            rs485_addr_en <= 1'b0;
            timeout_compare_value <= `RESET_TIMEOUT;
        end else if (ce && wr_en) begin
            if (addr == `OFS_ENABLE) begin
                enable_bits <= wdata[5:0];
            end
            if (addr == `OFS_FIFO_CTRL) begin
                rx_trigger_level <= wdata[4:0];
                rs485_addr_en <= wdata[`CTRL_RS485_ADDR_EN];
            end
            if (addr == `OFS_TIMEOUT) begin
                timeout_compare_value <= wdata[7:0];
            end
        end
    end

    // ****************************************************************
    // Source flags cleared by writing one
    // ****************************************************************
    // All of these live in the FIFO status and modem registers, not in status
    always @(posedge mclk) begin
        if (reset) begin
            rx_over_flag <= 1'b0;
            tx_over_flag <= 1'b0;
            break_flag <= 1'b0;
            framing_error_flag <= 1'b0;
            parity_error_flag <= 1'b0;
            rs485_addr_detect_flag <= 1'b0;
            cts_delta_flag <= 1'b0;
            cts_prev <= 1'b0;
        end else if (ce) begin
            rx_over_flag <= next_sticky(rx_over_flag, rx_overflow_now,
                clr_rx_over);
            tx_over_flag <= next_sticky(tx_over_flag, tx_overflow_event,
                clr_tx_over);
            break_flag <= next_sticky(break_flag, break_event,
                clr_break);
            framing_error_flag <= next_sticky(framing_error_flag, framing_event,
                clr_framing);
            parity_error_flag <= next_sticky(parity_error_flag, parity_event,
                clr_parity);
            rs485_addr_detect_flag <= next_sticky(rs485_addr_detect_flag, addr_char_now,
                clr_addr_det);
            cts_delta_flag <= next_sticky(cts_delta_flag, cts_changed,
                clr_cts_delta);
            cts_prev <= cts_level;
        end
    end

    // ****************************************************************
    // Summary flags derived from sources
    // ****************************************************************
    // Pure ORs, so they drop only once every contributing source is clear
    assign buffer_error_flag = tx_over_flag | rx_over_flag;
    assign line_status_flag = break_flag | framing_error_flag | parity_error_flag
        | rs485_addr_detect_flag;
    assign cts_change_flag = cts_delta_flag;

    // ****************************************************************
    // Flags owned by this block
    // ****************************************************************
    // Receive available is a level compare, so crossing down clears it at once
    always @(posedge mclk) begin
        if (reset) begin
            timeout_flag <= 1'b0;
            tx_empty_flag <= `RESET_TX_EMPTY;
            rx_avail_flag <= 1'b0;
        end else if (ce) begin
            timeout_flag <= next_sticky(timeout_flag, timeout_hit,
                rd_data | (rx_fifo_count == 5'h00));
            tx_empty_flag <= next_sticky(tx_empty_flag, tx_last_to_shift,
                wr_data);
            rx_avail_flag <= (rx_fifo_count >= rx_trigger_level)
                && (rx_fifo_count != 5'h00);
        end
    end

    // ****************************************************************
    // Status word assembly
    // ****************************************************************
    assign flags[`BIT_RX_AVAIL] = rx_avail_flag;
    assign flags[`BIT_TX_EMPTY] = tx_empty_flag;
    assign flags[`BIT_LINE_STATUS] = line_status_flag;
    assign flags[`BIT_CTS_CHANGE] = cts_change_flag;
    assign flags[`BIT_RX_TIMEOUT] = timeout_flag;
    assign flags[`BIT_BUFFER_ERROR] = buffer_error_flag;
    assign indicators = flags & enable_bits;
    // Reserved gaps stay tied low
    assign status_word = {18'h0_0000, indicators, 2'b00, flags};

    assign fifo_status_word = {7'h00, tx_over_flag, 11'h000, rx_fifo_count,
        1'b0, break_flag, framing_error_flag, parity_error_flag,
        rs485_addr_detect_flag, 2'b00, rx_over_flag};

    // ****************************************************************
    // Read multiplexer
    // ****************************************************************
    // Unmapped offsets and the write-only data port read back as zero
    always @* begin
        next_rdata = 32'h0000_0000;
        case (addr)
            `OFS_ENABLE: begin
                next_rdata = {26'h000_0000, enable_bits};
            end
            `OFS_FIFO_CTRL: begin
                next_rdata = {23'h00_0000, rs485_addr_en, 3'b000, rx_trigger_level};
            end
            `OFS_MODEM: begin
                next_rdata = {27'h000_0000, cts_level, 3'b000, cts_delta_flag};
            end
            `OFS_FIFO_STATUS: begin
                next_rdata = fifo_status_word;
            end
            `OFS_INT_STATUS: begin
                next_rdata = status_word;
            end
            `OFS_TIMEOUT: begin
                next_rdata = {24'h00_0000, timeout_compare_value};
            end
            default: begin
                next_rdata = 32'h0000_0000;
            end
        endcase
    end

    // ****************************************************************
    // Registered outputs
    // ****************************************************************
    // Read data is valid only in the cycle after the strobe, zero otherwise
    always @(posedge mclk) begin
        if (reset) begin
            rdata <= 32'h0000_0000;
            rx_buf_read <= 1'b0;
            tx_hold_write <= 1'b0;
            int_status <= `RESET_INT_STATUS;
        end else if (ce) begin
            rdata <= rd_en ? next_rdata : 32'h0000_0000;
            rx_buf_read <= rd_data;
            tx_hold_write <= wr_data;
            // Mirror lags the flags by one cycle; no write path reaches it
            int_status <= status_word;
        end
    end

endmodule // uart_interrupt_status

//--- hw/uart_isr_consts.vh
// Offsets, field positions, reset values and sizes of the UART interrupt status block
`ifndef UART_ISR_CONSTS_VH
`define UART_ISR_CONSTS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_DATA 8'h00
`define OFS_ENABLE 8'h04
`define OFS_FIFO_CTRL 8'h08
`define OFS_MODEM 8'h10
`define OFS_FIFO_STATUS 8'h18
`define OFS_INT_STATUS 8'h1c
`define OFS_TIMEOUT 8'h20

// ****************************************************************
// Interrupt status and enable field positions
// ****************************************************************
`define BIT_RX_AVAIL 0
`define BIT_TX_EMPTY 1
`define BIT_LINE_STATUS 2
`define BIT_CTS_CHANGE 3
`define BIT_RX_TIMEOUT 4
`define BIT_BUFFER_ERROR 5
`define IND_SHIFT 8

// ****************************************************************
// FIFO status, modem and control field positions
// ****************************************************************
`define FS_RX_OVER 0
`define FS_ADDR_DET 3
`define FS_PARITY 4
`define FS_FRAMING 5
`define FS_BREAK 6
`define FS_TX_OVER 24
`define FS_COUNT_LSB 8
`define MODEM_CTS_DELTA 0
`define MODEM_CTS_LEVEL 4
`define CTRL_RS485_ADDR_EN 8

// ****************************************************************
// Sizes and reset values
// ****************************************************************
`define RX_FIFO_DEPTH 5'h10
`define RESET_INT_STATUS 32'h0000_0002
`define RESET_TX_EMPTY 1'b1
`define RESET_ENABLE 6'h00
`define RESET_TRIGGER 5'h01
`define RESET_TIMEOUT 8'h00

`endif

//--- verif/serial_partner.sv
// Behavioural far side: receive FIFO occupancy, line events, CTS and baud ticks
`timescale 1ns/100ps

module serial_partner (
    input wire mclk,
    input wire reset,
    input wire rx_buf_read,
    output reg rx_push,
    output reg rx_char_bit9,
    output reg [4:0] rx_fifo_count,
    output reg tx_overflow_event,
    output reg tx_last_to_shift,
    output reg break_event,
    output reg framing_event,
    output reg parity_event,
    output reg cts_level,
    output reg baud_tick
);
    // ****************************************
    // Line activity
    // ****************************************
    // Everything idles low so no stray event reaches the block
    initial begin
        {rx_push, rx_char_bit9, tx_overflow_event, tx_last_to_shift} = 4'h0;
        {break_event, framing_event, parity_event, cts_level, baud_tick} = 5'h00;
        rx_fifo_count = 5'h00;
    end

    // Occupancy saturates at 16; a push when full is the overflow case
    always @(posedge mclk) begin
        if (reset)
            rx_fifo_count <= 5'h00;
        else if (rx_push && rx_fifo_count != 5'h10)
            rx_fifo_count <= rx_fifo_count + 5'h01;
        else if (rx_buf_read && rx_fifo_count != 5'h00)
            rx_fifo_count <= rx_fifo_count - 5'h01;
    end

    task push(input b9);
        @(posedge mclk) {rx_push, rx_char_bit9} <= {1'b1, b9};
        @(posedge mclk) {rx_push, rx_char_bit9} <= 2'b00;
    endtask

    // Bits: tx overflow, tx last, break, framing, parity
    task ev(input [4:0] m);
        @(posedge mclk)
            {tx_overflow_event, tx_last_to_shift, break_event, framing_event, parity_event} <= m;
        @(posedge mclk)
            {tx_overflow_event, tx_last_to_shift, break_event, framing_event, parity_event} <= 5'h00;
    endtask

    task tick(input int n);
        repeat (n) begin
            @(posedge mclk) baud_tick <= 1'b1;
            @(posedge mclk) baud_tick <= 1'b0;
        end
    endtask

    // Extra edges let the change pass the input stage
    task set_cts(input v);
        @(posedge mclk) cts_level <= v;
        repeat (2) @(posedge mclk);
    endtask
endmodule // serial_partner

//--- verif/uart_interrupt_status_asserts.sv
// Port assertions for the UART interrupt status block
`timescale 1ns/100ps

module uart_interrupt_status_asserts (
    input logic mclk,
    input logic reset,
    input logic ce,
    input logic [7:0] addr,
    input logic wr_en,
    input logic rd_en,
    input logic [31:0] rdata,
    input logic rx_push,
    input logic [4:0] rx_fifo_count,
    input logic tx_overflow_event,
    input logic tx_last_to_shift,
    input logic break_event,
    input logic framing_event,
    input logic parity_event,
    input logic cts_level,
    input logic rx_buf_read,
    input logic tx_hold_write,
    input logic [31:0] int_status
);
    // ****************************************
    // Status relations
    // ****************************************
    // Source pulses land in the flag one edge later, in int_status one more
    default clocking @(posedge mclk); endclocking
    // Frozen cycles drop pending attempts, since no flag may move while ce is low
    default disable iff (reset || !ce);

    chk_ind_gated: assert property ((int_status[13:8] & ~int_status[5:0]) == 6'h00)
        else $error("indicator set without its flag");
    chk_reserved_zero: assert property (int_status[31:14] == 18'h0_0000
        && int_status[7:6] == 2'b00)
        else $error("reserved status bits not zero");
    chk_buf_err_set: assert property (tx_overflow_event |-> ##2 int_status[5])
        else $error("buffer error flag missed overflow");
    chk_line_set: assert property ((break_event || framing_event || parity_event)
        |-> ##2 int_status[2])
        else $error("line status flag missed error");
    chk_tx_empty_set: assert property (tx_last_to_shift |-> ##2 int_status[1])
        else $error("tx empty flag not set");
    chk_tx_write_clear: assert property ((wr_en && addr == 8'h00 && !tx_last_to_shift)
        |-> ##2 !int_status[1])
        else $error("tx empty flag not cleared by write");
    chk_modem_set: assert property ($changed(cts_level) |-> ##[1:3] int_status[3])
        else $error("cts change flag not set");
    chk_avail_empty: assert property ((rx_fifo_count == 5'h00) [*3] |-> !int_status[0])
        else $error("rx available flag with empty fifo");
    chk_data_read: assert property ((rd_en && addr == 8'h00) |=> rx_buf_read)
        else $error("data read pulse missing");
    chk_data_write: assert property ((wr_en && addr == 8'h00) |=> tx_hold_write)
        else $error("data write pulse missing");
    chk_read_status: assert property ((rd_en && addr == 8'h1c) |=> rdata == int_status)
        else $error("status read differs from status port");

    cov_overflow: cover property (rx_push && rx_fifo_count == 5'h10);
    cov_timeout: cover property (int_status[12]);
    cov_line_ind: cover property (int_status[10]);
endmodule // uart_interrupt_status_asserts

bind uart_interrupt_status uart_interrupt_status_asserts i_uart_interrupt_status_asserts (
    .mclk, .reset, .ce, .addr, .wr_en, .rd_en, .rdata, .rx_push, .rx_fifo_count,
    .tx_overflow_event, .tx_last_to_shift, .break_event, .framing_event, .parity_event,
    .cts_level, .rx_buf_read, .tx_hold_write, .int_status);

//--- verif/uart_interrupt_status_tb.sv
// Self-checking testbench for the UART interrupt status block
`timescale 1ns/100ps

`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin num_errors++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, a); end end

module uart_interrupt_status_tb;
    reg mclk = 1'b0;
    reg reset = 1'b1;
    reg ce = 1'b1;
    reg [7:0] addr = 8'h00;
    reg [31:0] wdata = 32'h0000_0000;
    reg wr_en = 1'b0;
    reg rd_en = 1'b0;
    wire [31:0] rdata;
    wire [31:0] int_status;
    wire rx_push, rx_char_bit9, tx_overflow_event, tx_last_to_shift, break_event, framing_event;
    wire parity_event, cts_level, baud_tick, rx_buf_read, tx_hold_write;
    wire [4:0] rx_fifo_count;
    int num_errors = 0;
    int checks_done = 0;
    reg [31:0] v;

    uart_interrupt_status i_uart_interrupt_status (.mclk, .reset, .ce, .addr, .wdata, .wr_en,
        .rd_en, .rdata, .rx_push, .rx_char_bit9, .rx_fifo_count, .tx_overflow_event,
        .tx_last_to_shift, .break_event, .framing_event, .parity_event, .cts_level, .baud_tick,
        .rx_buf_read, .tx_hold_write, .int_status);
    serial_partner i_serial_partner (.mclk, .reset, .rx_buf_read, .rx_push, .rx_char_bit9,
        .rx_fifo_count, .tx_overflow_event, .tx_last_to_shift, .break_event, .framing_event,
        .parity_event, .cts_level, .baud_tick);

    // ****************************************
    // Bus access and helpers
    // ****************************************
    initial begin
        forever #5 mclk = ~mclk;
    end

    // Flags mirrored into indicators, since every chk_st call runs with all enables on
    function [31:0] st(input [5:0] f);
        st = {18'h0_0000, f, 2'b00, f};
    endfunction

    task wr(input [7:0] a, input [31:0] d);
        @(posedge mclk) {addr, wdata, wr_en} <= {a, d, 1'b1};
        @(posedge mclk) wr_en <= 1'b0;
    endtask

    // Read data is only valid in the cycle after the strobe
    task rd(input [7:0] a, output [31:0] d);
        @(posedge mclk) {addr, rd_en} <= {a, 1'b1};
        @(posedge mclk) rd_en <= 1'b0;
        #1 d = rdata;
    endtask

    // One spare edge lets a pop from a data read reach the count and the flag first
    task chk_st(input [5:0] f);
        @(posedge mclk);
        rd(8'h1c, v);
        `CHK("status", st(f), v)
        `CHK("status port", st(f), int_status)
    endtask

    task complete_run;
        if (num_errors == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task t_reset_ro;
        rd(8'h1c, v);
        `CHK("reset status", 32'h0000_0002, v)
        wr(8'h1c, 32'hffff_ffff);
        rd(8'h1c, v);
        `CHK("status after write", 32'h0000_0002, v)
        rd(8'hfc, v);
        `CHK("unmapped read", 32'h0000_0000, v)
        wr(8'h04, 32'h0000_0001);
        rd(8'h1c, v);
        `CHK("masked indicator", 32'h0000_0002, v)
        wr(8'h04, 32'h0000_003f);
        chk_st(6'h02);
    endtask

    task t_tx_empty;
        wr(8'h00, 32'h0000_0055);
        chk_st(6'h00);
        i_serial_partner.ev(5'h08);
        chk_st(6'h02);
    endtask

    // Each error alone, then two together with a partial clear
    task t_line;
        for (int i = 0; i < 3; i++) begin
            i_serial_partner.ev(5'h04 >> i);
            chk_st(6'h06);
            wr(8'h18, 32'h0000_0040 >> i);
            chk_st(6'h02);
        end
        i_serial_partner.ev(5'h05);
        wr(8'h18, 32'h0000_0040);
        chk_st(6'h06);
        wr(8'h18, 32'h0000_0010);
        chk_st(6'h02);
        wr(8'h08, 32'h0000_0101);
        i_serial_partner.push(1'b1);
        chk_st(6'h07);
        rd(8'h18, v);
        `CHK("address detect", 1'b1, v[3])
        wr(8'h18, 32'h0000_0008);
        chk_st(6'h03);
        rd(8'h00, v);
        chk_st(6'h02);
    endtask

    task t_modem;
        i_serial_partner.set_cts(1'b1);
        chk_st(6'h0a);
        wr(8'h10, 32'h0000_0001);
        chk_st(6'h02);
    endtask

    task t_avail;
        wr(8'h08, 32'h0000_0004);
        repeat (3) i_serial_partner.push(1'b0);
        chk_st(6'h02);
        i_serial_partner.push(1'b1);
        chk_st(6'h03);
        rd(8'h00, v);
        chk_st(6'h02);
        repeat (3) rd(8'h00, v);
    endtask

    // While frozen, neither a line error nor an enable write may land
    task t_freeze;
        @(posedge mclk) ce <= 1'b0;
        i_serial_partner.ev(5'h04);
        wr(8'h04, 32'h0000_0000);
        @(posedge mclk) ce <= 1'b1;
        chk_st(6'h02);
    endtask

    // A second push restarts the count, so four ticks total stay short of three
    task t_timeout;
        wr(8'h20, 32'h0000_0003);
        wr(8'h08, 32'h0000_0001);
        i_serial_partner.push(1'b0);
        i_serial_partner.tick(2);
        i_serial_partner.push(1'b0);
        i_serial_partner.tick(2);
        chk_st(6'h03);
        i_serial_partner.tick(1);
        chk_st(6'h13);
        rd(8'h00, v);
        chk_st(6'h03);
        rd(8'h00, v);
    endtask

    task t_overflow;
        repeat (16) i_serial_partner.push(1'b0);
        chk_st(6'h03);
        i_serial_partner.push(1'b0);
        chk_st(6'h23);
        rd(8'h18, v);
        `CHK("rx overflow", 1'b1, v[0])
        i_serial_partner.ev(5'h10);
        wr(8'h18, 32'h0000_0001);
        chk_st(6'h23);
        wr(8'h18, 32'h0100_0000);
        chk_st(6'h03);
    endtask

    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial begin
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        t_reset_ro();
        t_tx_empty();
        t_line();
        t_modem();
        t_freeze();
        t_avail();
        t_timeout();
        t_overflow();
        complete_run();
    end

    // Whole run is a few hundred cycles; this leaves wide margin
    initial begin
        #200000;
        num_errors++;
        complete_run();
    end
endmodule // uart_interrupt_status_tb
